/* src/sirp_pkg.sv */
package sirp_pkg;
   localparam logic [15:0] REG_DEST_TAG = 16'h1847;
   localparam logic [15:0] REG_BC_THROT = 16'h1848;
   localparam logic [15:0] REG_ADMIT = 16'h1849;
   localparam logic [15:0] REG_MODE = 16'h184a;
   localparam logic [15:0] REG_CMD = 16'h184b;
   localparam logic [15:0] REG_CMD_STATE = 16'h184c;
   localparam logic [15:0] REG_WDATA = 16'h184d;
   localparam logic [15:0] REG_RDATA = 16'h184e;
   localparam int NPORT = 3;
   localparam int NCIR = 24;
   localparam int LVL_W = 8;
   localparam int THR_FLD = 9;
   localparam int CNT_W = 14;
   localparam int TICK_W = 16;
   localparam logic [1:0] DEST_TAG_ON = 2'b11;
   localparam logic [7:0] THR_LVL_RST = 8'h02;
   localparam logic [15:0] CIR_RST = 16'h0014;
   localparam logic [15:0] BURST_RST = 16'h0600;
   localparam int CMD_DIR_BIT = 7;
   localparam logic [1:0] TYP_CIR = 2'b01;
   localparam logic [1:0] TYP_CBS = 2'b10;
   localparam logic [1:0] TYP_EBS = 2'b11;
   localparam logic [1:0] MODE_PORT_PRI = 2'b00;
   localparam logic [1:0] MODE_PORT = 2'b01;
   localparam logic [1:0] MODE_PRI = 2'b10;
   localparam int CLK_PERIOD_NS = 40;
   localparam int THR_INTERVAL_NS = 1720000;
   localparam int THR_INTERVAL_CYC = THR_INTERVAL_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } sirp_req_t;

   typedef struct packed {
      logic [1:0] port;
      logic [2:0] prio;
   } sirp_key_t;
endpackage

/* src/sirp_regs.sv */
`timescale 1ns/10ps
// How it works
// RULE1 - port type 11b selects destination by tag
// RULE2 - per-port throttle enables at 26,17,8
// RULE3 - admit level times 64 bytes per interval
// RULE4 - levels reset 02h, enables reset cleared
// RULE5 - outsider bit admits non-member packets
// RULE6 - one admit bit per port, reset zero
// RULE7 - mode bits 2:1 choose metering basis
// RULE8 - enable bit 0 turns metering on
// RULE9 - writing command starts table access
// RULE10 - software reads data after pending clears
// RULE11 - software loads write data before command
// RULE12 - command bit 7: 1 read, 0 write
// RULE13 - type 01 rate, 10 committed, 11 excess
// RULE14 - address 4:0 picks one of 24 entries
// RULE15 - port-priority mode: eight entries per port
// RULE16 - port-only mode: entries 0,1,2 per port
// RULE17 - priority-only mode: entry n is priority n
// RULE18 - software keeps entry address in range
// RULE19 - pending set while command runs, self-clears
// RULE20 - rate entries reset to 0014h
// RULE21 - table entries are 16 bits wide
// RULE22 - reserved bits read zero, ignore writes
module sirp_regs
   import sirp_pkg::*;
#(
   parameter int INTERVAL_CYC = THR_INTERVAL_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input sirp_req_t reg_req,
   output logic [31:0] reg_rdata,
   output logic [NPORT-1:0] dest_by_tag,
   output logic [NPORT-1:0] outsider_admit,
   input wire logic [NPORT-1:0] bcast_byte,
   output logic [NPORT-1:0] bcast_drop,
   output logic meter_en,
   output logic [1:0] meter_mode,
   input sirp_key_t meter_key,
   output logic [15:0] meter_rate,
   output logic [15:0] meter_cbs,
   output logic [15:0] meter_ebs,
   output logic cmd_pending
);
   typedef struct packed {
      logic [5:0] ptype;
      logic [26:0] thr;
      logic [2:0] admit;
      logic [2:0] mcfg;
      logic [7:0] cmd;
      logic pend;
      logic [15:0] wdat;
      logic [15:0] rdat;
      logic [NCIR-1:0][15:0] committed_rate_entry;
      logic [15:0] cbs;
      logic [15:0] ebs;
      logic [NPORT-1:0][CNT_W-1:0] bcnt;
      logic [TICK_W-1:0] tick;
      logic [15:0] rate;
      logic [31:0] rd_q;
   } sirp_state_t;

   // constant reset image: the async branch loads no logic
   localparam sirp_state_t ST_RST = '{
      thr: {1'b0, THR_LVL_RST, 1'b0, THR_LVL_RST,
         1'b0, THR_LVL_RST}, // [RULE4]
      committed_rate_entry: {NCIR{CIR_RST}}, // [RULE20]
      cbs: BURST_RST,
      ebs: BURST_RST,
      default: '0
   };

   sirp_state_t st;
   sirp_state_t next_st;
   logic tick_hit;
   logic [NPORT-1:0] thr_en;
   logic [NPORT-1:0][CNT_W-1:0] thr_cap;
   logic [4:0] lk_idx;
   logic [4:0] cmd_idx;

   assign tick_hit = (st.tick == TICK_W'(INTERVAL_CYC - 1));

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_port
         assign dest_by_tag[g] =
            (st.ptype[2*g +: 2] == DEST_TAG_ON); // [RULE1]
         assign thr_en[g] = st.thr[THR_FLD*g + LVL_W]; // [RULE2]
         assign thr_cap[g] =
            {st.thr[THR_FLD*g +: LVL_W], 6'h00}; // [RULE3]
         // limit reached: further broadcast bytes are refused
         assign bcast_drop[g] =
            thr_en[g] && (st.bcnt[g] >= thr_cap[g]); // [RULE3]
         assign outsider_admit[g] = st.admit[g]; // [RULE5] [RULE6]
      end
   endgenerate

   // reserved mode 11 falls back to entry 0
   always_comb begin
      case (st.mcfg[2:1]) // [RULE7]
         MODE_PORT_PRI: lk_idx = {meter_key.port,
            meter_key.prio}; // [RULE15]
         MODE_PORT: lk_idx = {3'h0, meter_key.port}; // [RULE16]
         MODE_PRI: lk_idx = {2'h0, meter_key.prio}; // [RULE17]
         default: lk_idx = 5'h00;
      endcase
   end

   assign cmd_idx = st.cmd[4:0];

   always_comb begin
      next_st = st;
      // interval counter only matters for throttling
      next_st.tick = tick_hit ? '0 : st.tick + 1'b1;
      for (int p = 0; p < NPORT; p++) begin
         if (tick_hit) begin
            next_st.bcnt[p] = '0; // [RULE3]
         end else if (thr_en[p] && bcast_byte[p] &&
               !bcast_drop[p]) begin
            next_st.bcnt[p] = st.bcnt[p] + 1'b1; // [RULE3]
         end
      end
      // rate index beyond 23 reads entry 0, outside valid use
      next_st.rate = (lk_idx < 5'(NCIR)) ? st.committed_rate_entry[lk_idx] :
         st.committed_rate_entry[0];
      if (st.pend) begin
         next_st.pend = 1'b0; // [RULE19]
         if (st.cmd[CMD_DIR_BIT]) begin // [RULE12]
            case (st.cmd[6:5]) // [RULE13]
               TYP_CIR: if (cmd_idx < 5'(NCIR)) begin
                  next_st.rdat = st.committed_rate_entry[cmd_idx]; // [RULE14]
               end
               TYP_CBS: next_st.rdat = st.cbs;
               TYP_EBS: next_st.rdat = st.ebs;
               default: next_st.rdat = st.rdat;
            endcase
         end else begin
            case (st.cmd[6:5]) // [RULE13]
               TYP_CIR: if (cmd_idx < 5'(NCIR)) begin
                  next_st.committed_rate_entry[cmd_idx] = st.wdat; // [RULE14] [RULE21]
               end
               TYP_CBS: next_st.cbs = st.wdat; // [RULE21]
               TYP_EBS: next_st.ebs = st.wdat;
               default: next_st.cbs = st.cbs;
            endcase
         end
      end
      if (reg_req.wr) begin
         case (reg_req.addr) // [RULE22]
            REG_DEST_TAG: next_st.ptype = reg_req.wdata[5:0];
            REG_BC_THROT: next_st.thr = reg_req.wdata[26:0];
            REG_ADMIT: next_st.admit = reg_req.wdata[2:0];
            REG_MODE: next_st.mcfg = reg_req.wdata[2:0];
            REG_CMD: begin
               next_st.cmd = reg_req.wdata[7:0];
               // a new command wins over the self-clear
               next_st.pend = 1'b1; // [RULE9] [RULE19]
            end
            REG_WDATA: next_st.wdat = reg_req.wdata[15:0];
            default: next_st.ptype = next_st.ptype;
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr) // [RULE22]
            REG_DEST_TAG: next_st.rd_q = {26'h0, st.ptype};
            REG_BC_THROT: next_st.rd_q = {5'h00, st.thr};
            REG_ADMIT: next_st.rd_q = {29'h0, st.admit};
            REG_MODE: next_st.rd_q = {29'h0, st.mcfg};
            REG_CMD: next_st.rd_q = {24'h0, st.cmd};
            REG_CMD_STATE: next_st.rd_q = {31'h0, st.pend};
            REG_WDATA: next_st.rd_q = {16'h0, st.wdat};
            REG_RDATA: next_st.rd_q = {16'h0, st.rdat}; // [RULE21]
            default: next_st.rd_q = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rd_q;
   assign meter_en = st.mcfg[0]; // [RULE8]
   assign meter_mode = st.mcfg[2:1]; // [RULE7]
   assign meter_rate = st.rate;
   assign meter_cbs = st.cbs;
   assign meter_ebs = st.ebs;
   assign cmd_pending = st.pend; // [RULE19]

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic cmd_wr;
   assign cmd_wr = reg_req.wr && (reg_req.addr == REG_CMD);

   a_cmd_starts: assert property ( // [RULE9]
      cmd_wr |=> cmd_pending)
      else $error("command write did not raise pending");

   a_pend_clears: assert property ( // [RULE19]
      cmd_pending && !cmd_wr |=> !cmd_pending)
      else $error("pending did not self-clear");

   a_dest_tag: assert property ( // [RULE1]
      reg_req.wr && reg_req.addr == REG_DEST_TAG
      |=> dest_by_tag[2] == (&$past(reg_req.wdata[5:4])))
      else $error("destination tag enable wrong");

   a_drop_needs: assert property ( // [RULE2]
      bcast_drop[1] |-> st.thr[17])
      else $error("drop without throttle enable");

   a_thr_count: assert property ( // [RULE3]
      thr_en[0] && bcast_byte[0] && !bcast_drop[0] && !tick_hit
      |=> st.bcnt[0] == $past(st.bcnt[0]) + 1'b1)
      else $error("broadcast byte not counted");

   a_admit_bits: assert property ( // [RULE6]
      reg_req.wr && reg_req.addr == REG_ADMIT
      |=> outsider_admit == $past(reg_req.wdata[2:0]))
      else $error("admit bits not stored");

   a_meter_en: assert property ( // [RULE8]
      reg_req.wr && reg_req.addr == REG_MODE
      |=> meter_en == $past(reg_req.wdata[0]))
      else $error("metering enable not stored");

   a_rd_entry: assert property ( // [RULE14]
      cmd_pending && !cmd_wr && st.cmd[7:5] == 3'b101
      && st.cmd[4:0] < 5'd24
      |=> st.rdat == $past(st.committed_rate_entry[st.cmd[4:0]]))
      else $error("rate entry read wrong");

   a_wr_burst: assert property ( // [RULE13]
      cmd_pending && st.cmd[7:5] == 3'b010
      |=> meter_cbs == $past(st.wdat))
      else $error("committed burst not written");

   a_port_mode: assert property ( // [RULE16]
      meter_mode == MODE_PORT && !(reg_req.wr && cmd_pending)
      |=> meter_rate == $past(st.committed_rate_entry[meter_key.port]))
      else $error("port-only lookup wrong");

   a_rsvd_zero: assert property ( // [RULE22]
      reg_req.rd && reg_req.addr == REG_BC_THROT
      |=> reg_rdata[31:27] == 5'h00)
      else $error("reserved bits not zero");

   a_ebs_write: assert property ( // [RULE13]
      cmd_pending && st.cmd[7:5] == 3'h3
      |=> meter_ebs == $past(st.wdat))
      else $error("excess burst not written");

   a_cbs_read: assert property ( // [RULE12]
      cmd_pending && st.cmd[7:5] == 3'h6
      |=> st.rdat == $past(st.cbs))
      else $error("committed burst read wrong");

   a_ebs_read: assert property ( // [RULE12]
      cmd_pending && st.cmd[7:5] == 3'h7
      |=> st.rdat == $past(st.ebs))
      else $error("excess burst read wrong");

   a_rate_write: assert property ( // [RULE14]
      cmd_pending && !cmd_wr && st.cmd[7:5] == 3'h1
      && cmd_idx < 5'(NCIR)
      |=> st.committed_rate_entry[cmd_idx] == $past(st.wdat))
      else $error("rate entry write wrong");

   a_rsvd_type: assert property ( // [RULE13]
      cmd_pending && st.cmd[6:5] == 2'h0
      |=> $stable(st.committed_rate_entry) && $stable(st.rdat) && $stable(meter_cbs)
      && $stable(meter_ebs))
      else $error("reserved command type changed the table");

   a_wdata_store: assert property ( // [RULE21]
      reg_req.wr && reg_req.addr == REG_WDATA
      |=> st.wdat == $past(reg_req.wdata[15:0]))
      else $error("write data not stored");

   a_rdata_upper: assert property ( // [RULE21]
      reg_req.rd && reg_req.addr == REG_RDATA
      |=> reg_rdata[31:16] == 16'h0000)
      else $error("read data upper bits not zero");

   a_mode_bits: assert property ( // [RULE7]
      reg_req.wr && reg_req.addr == REG_MODE
      |=> meter_mode == $past(reg_req.wdata[2:1]))
      else $error("metering mode not stored");

   a_pri_mode: assert property ( // [RULE17]
      meter_mode == MODE_PRI
      |=> meter_rate == $past(st.committed_rate_entry[meter_key.prio]))
      else $error("priority-only lookup wrong");

   a_port_pri_mode: assert property ( // [RULE15]
      meter_mode == MODE_PORT_PRI && meter_key.port != 2'h3
      |=> meter_rate == $past(st.committed_rate_entry[{meter_key.port, meter_key.prio}]))
      else $error("port-priority lookup wrong");

   a_thr_enable: assert property ( // [RULE2]
      reg_req.wr && reg_req.addr == REG_BC_THROT
      |=> thr_en == {$past(reg_req.wdata[26]), $past(reg_req.wdata[17]),
      $past(reg_req.wdata[8])})
      else $error("throttle enables not stored");

   a_interval_clear: assert property ( // [RULE3]
      tick_hit |=> st.bcnt == '0)
      else $error("byte counts not cleared at interval end");

   a_drop_holds: assert property ( // [RULE3]
      bcast_drop[2] && !tick_hit
      && !(reg_req.wr && reg_req.addr == REG_BC_THROT)
      |=> bcast_drop[2])
      else $error("broadcast drop released early");

   a_tag_port0: assert property ( // [RULE1]
      reg_req.wr && reg_req.addr == REG_DEST_TAG
      |=> dest_by_tag[0] == (&$past(reg_req.wdata[1:0])))
      else $error("port 0 destination tag enable wrong");

   a_pend_read: assert property ( // [RULE19]
      reg_req.rd && reg_req.addr == REG_CMD_STATE
      |=> reg_rdata == {31'h0, $past(cmd_pending)})
      else $error("pending status read wrong");

   a_cmd_rsvd: assert property ( // [RULE22]
      reg_req.rd && reg_req.addr == REG_CMD
      |=> reg_rdata[31:8] == 24'h0)
      else $error("command reserved bits not zero");

   a_pend_source: assert property ( // [RULE19]
      !cmd_pending && !cmd_wr |=> !cmd_pending)
      else $error("pending rose without a command");

   c_tbl_read: cover property (
      cmd_wr && reg_req.wdata[7] ##1 cmd_pending ##1 !cmd_pending);
   c_tbl_write: cover property (
      cmd_wr && !reg_req.wdata[7] ##2 !cmd_pending);
   c_bc_drop: cover property (bcast_drop[0] && bcast_byte[0]);
   c_interval: cover property (tick_hit && thr_en[2]);
   c_drop_ends: cover property (bcast_drop[0] ##1 !bcast_drop[0]);
endmodule

/* tb/switch_ingress_policy_regs_test.sv */
`timescale 1ns/10ps
module switch_ingress_policy_regs_test;
   import sirp_pkg::*;
   localparam int IVL = 200;
   localparam logic [31:0] MSK [4] = '{32'h3f, 32'h07ffffff, 32'h7, 32'h7};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   sirp_req_t req = '0;
   sirp_key_t key = '0;
   logic [2:0] bbyte = '0;
   logic [31:0] rdata;
   logic [2:0] dtag, oadm, drop, e3;
   logic men, pend;
   logic [1:0] mmode;
   logic [15:0] mrate, mcbs, mebs, last_rd;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int tab [26];
   logic [31:0] shd [4];
   int i, n, lo, hi;
   logic [1:0] t;
   logic [4:0] a;

   sirp_regs #(.INTERVAL_CYC(IVL)) u_sirp_regs (.clk(clk), .rst_n(rst_n),
      .reg_req(req), .reg_rdata(rdata), .dest_by_tag(dtag),
      .outsider_admit(oadm), .bcast_byte(bbyte), .bcast_drop(drop),
      .meter_en(men), .meter_mode(mmode), .meter_key(key),
      .meter_rate(mrate), .meter_cbs(mcbs), .meter_ebs(mebs),
      .cmd_pending(pend));

   always #20 clk = ~clk;

   task finish_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task wr(input logic [15:0] ad, input logic [31:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= ad;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task rd(input logic [15:0] ad, input logic [31:0] e);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= ad;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk("reg_rdata", e, rdata);
   endtask

   // table access through write data, command and read data registers
   task tab_op(input logic r, input logic [1:0] ty, input logic [4:0] ad,
               input logic [15:0] d);
      int idx;
      idx = (ty == 2'b01 && ad < 24) ? int'(ad) : (ty == 2'b10) ? 24 :
            (ty == 2'b11) ? 25 : -1;
      if (!r)
         wr(REG_WDATA, {16'hffff, d});
      wr(REG_CMD, {24'hffffff, r, ty, ad});
      #1 chk("cmd_pending", 32'h1, {31'h0, pend});
      @(posedge clk);
      #1 chk("cmd_pending", 32'h0, {31'h0, pend});
      if (idx >= 0 && r)
         last_rd = tab[idx][15:0];
      if (idx >= 0 && !r)
         tab[idx] = int'(d);
      rd(REG_RDATA, {16'h0, last_rd});
      rd(REG_CMD, {24'h0, r, ty, ad});
      chk("meter_cbs", tab[24], {16'h0, mcbs});
      chk("meter_ebs", tab[25], {16'h0, mebs});
   endtask

   initial begin
      void'($urandom(32'he8a194b1));
      for (i = 0; i < 24; i++)
         tab[i] = 32'h14;
      tab[24] = 32'h600;
      tab[25] = 32'h600;
      last_rd = '0;
      shd = '{32'h0, 32'h00080402, 32'h0, 32'h0};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++)
         rd(REG_DEST_TAG + 16'(i), shd[i]);
      rd(REG_CMD, 32'h0);
      rd(16'h1850, 32'h0);
      repeat (16) begin
         i = $urandom % 4;
         wr(REG_DEST_TAG + 16'(i), $urandom);
         shd[i] = $urandom;
         wr(REG_DEST_TAG + 16'(i), shd[i]);
         shd[i] = shd[i] & MSK[i];
         rd(REG_DEST_TAG + 16'(i), shd[i]);
         for (n = 0; n < 3; n++)
            e3[n] = (shd[0][2*n +: 2] == DEST_TAG_ON);
         chk("dest_by_tag", {29'h0, e3}, {29'h0, dtag});
         chk("outsider_admit", shd[2], {29'h0, oadm});
         chk("meter_cfg", shd[3], {29'h0, mmode, men});
         // enabled with level zero refuses every byte at once
         for (n = 0; n < 3; n++)
            e3[n] = shd[1][THR_FLD*n+LVL_W] &&
               (shd[1][THR_FLD*n +: LVL_W] == 8'h00);
         chk("bcast_drop", {29'h0, e3}, {29'h0, drop});
      end
      tab_op(1'b0, 2'b01, 5'd23, 16'hbeef);
      tab_op(1'b1, 2'b01, 5'd23, 16'h0);
      repeat (40) begin
         t = 2'($urandom);
         a = 5'($urandom % 24);
         tab_op(1'($urandom), t, a, 16'($urandom));
      end
      for (i = 0; i < 4; i++) begin
         wr(REG_MODE, {29'h0, 2'(i), 1'b1});
         repeat (8) begin
            @(posedge clk);
            key <= '{port: 2'($urandom % 3), prio: 3'($urandom)};
            @(posedge clk);
            #1;
            n = (i == 0) ? key.port * 8 + key.prio : (i == 1) ? key.port :
                (i == 2) ? key.prio : 0;
            chk("lookup", tab[n], 32'(mrate));
         end
      end
      // port 0 level 1 enabled, ports 1 and 2 disabled at level 2
      wr(REG_BC_THROT, 32'h00080501);
      @(posedge clk);
      bbyte <= 3'b111;
      lo = 0;
      hi = 0;
      n = 0;
      while (drop[0] !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      while (drop[0] === 1'b1 && n < 800) begin
         @(posedge clk);
         #1 n++;
      end
      while (drop[0] === 1'b0 && lo < 400) begin
         lo++;
         @(posedge clk);
         #1 chk("bcast_drop_other", 32'h0, {30'h0, drop[2:1]});
      end
      while (drop[0] === 1'b1 && hi < 400) begin
         hi++;
         @(posedge clk);
         #1;
      end
      chk("bytes_admitted", 32'd64, lo);
      chk("interval_cycles", IVL, lo + hi);
      bbyte <= 3'b000;
      finish_test();
   end
endmodule
